// ---- src/i2cie_top.sv ----
// Interrupt enable set/clear registers and interrupt gate of the two-wire controller.
// Assumes an APB master on REF_CLK and status flags arriving from the bus engine.
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Writing one to a defined set-register bit turns that enable on.
//- Reading the set register returns every present enable.
//- Only interrupt-capable positions hold enables; enable gates its flag.
//- Enable bit zero means disabled, one means enabled.
//- Bit 0 gates the master pending flag.
//- Bit 4 gates the master arbitration loss flag.
//- Bit 6 gates the master start/stop error flag.
//- Bit 8 gates the slave pending flag.
//- Bit 11 gates the slave not-stretching flag.
//- Bit 15 gates the slave deselect flag.
//- Bit 16 gates the monitor data-ready flag.
//- Bit 17 gates the monitor overrun flag.
//- Bit 19 gates the monitor idle flag.
//- Bit 24 gates the event time-out flag.
//- Bit 25 gates the clock-line time-out flag.
//- Writing one to the clear register clears the matching enable.
//- With DMA selected, master pending is not raised for DMA events.
module i2cie_top (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [i2cie_pkg::ADDR_W-1:0] PADDR,
	input wire logic [i2cie_pkg::DATA_W-1:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [i2cie_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [i2cie_pkg::DATA_W-1:0] STATUS_FLAGS,
	input wire logic DMA_EVENT,
	output logic MASTER_DMA_SELECT,
	output logic IRQ
);
	import i2cie_pkg::*;

	logic [DATA_W-1:0] interrupt_enable_set_q;
	logic [DATA_W-1:0] interrupt_enable_set_d;
	logic [DATA_W-1:0] control_q;
	logic [DATA_W-1:0] status_sync;
	logic dma_sync;
	logic [DATA_W-1:0] status_gated;
	logic [DATA_W-1:0] wmask;
	logic [DATA_W-1:0] prdata_q;
	logic pslverr_q;
	logic irq_q;
	logic master_pending_flag;
	logic master_dma_select;
	logic access;
	logic wr_set;
	logic wr_clr;
	logic wr_ctl;
	logic addr_ok;

	// Flags and the DMA event come from another block, so they are synchronised.
	i2cie_sync #(
		.WIDTH(DATA_W)
	) u_status_sync (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.d(STATUS_FLAGS),
		.q(status_sync)
	);

	i2cie_sync #(
		.WIDTH(1)
	) u_dma_sync (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.d(DMA_EVENT),
		.q(dma_sync)
	);

	// The slave always answers in the access cycle; no wait states are added.
	assign access = PSEL && PENABLE;
	assign PREADY = 1'b1;
	assign wr_set = access && PWRITE && (PADDR == OFS_ENABLE_SET);
	assign wr_clr = access && PWRITE && (PADDR == OFS_ENABLE_CLEAR);
	assign wr_ctl = access && PWRITE && (PADDR == OFS_CONTROL);

	// Address decode; the status view is read-only and the clear register write-only.
	always_comb begin
		if (PADDR == OFS_ENABLE_SET) begin
			addr_ok = 1'b1;
		end else if (PADDR == OFS_ENABLE_CLEAR) begin
			addr_ok = PWRITE;
		end else if (PADDR == OFS_INT_STATUS) begin
			addr_ok = !PWRITE;
		end else if (PADDR == OFS_CONTROL) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Byte strobes widen into a bit mask so partial writes touch only their lanes.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{PSTRB[gi]}} & PWDATA[gi*8 +: 8];
		end
	endgenerate

	// Set wins over clear when both land together, keeping a freshly enabled source.
	always_comb begin
		interrupt_enable_set_d = interrupt_enable_set_q;
		if (wr_clr) begin
			interrupt_enable_set_d = interrupt_enable_set_d & ~(wmask & ENABLE_MASK);
		end
		if (wr_set) begin
			interrupt_enable_set_d = interrupt_enable_set_d | (wmask & ENABLE_MASK);
		end
	end

	// Enables reset to zero, so no source can interrupt until software unmasks it.
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			interrupt_enable_set_q <= ENABLE_RESET;
		end else begin
			interrupt_enable_set_q <= interrupt_enable_set_d;
		end
	end

	// Control register holds the master DMA selection.
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			control_q <= CONTROL_RESET;
		end else if (wr_ctl && PSTRB[0]) begin
			control_q[POS_DMA_SELECT] <= PWDATA[POS_DMA_SELECT];
		end
	end

	assign master_dma_select = control_q[POS_DMA_SELECT];
	assign MASTER_DMA_SELECT = master_dma_select;

	// A master pending event serviced by DMA is hidden from the interrupt path.
	assign master_pending_flag = status_sync[POS_MST_PENDING] && !(master_dma_select && dma_sync);

	// Gate the flags: only defined positions pass, each by its own enable.
	always_comb begin
		status_gated = status_sync & ENABLE_MASK;
		status_gated[POS_MST_PENDING] = master_pending_flag;
	end

	// Registered interrupt, so the output is glitch free; it lags the synchronised flags by one clock.
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_gated & interrupt_enable_set_q);
		end
	end

	assign IRQ = irq_q;

	// Read data and error response are registered at the setup phase for the access.
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			pslverr_q <= !addr_ok;
			if (PWRITE) begin
				prdata_q <= '0;
			end else if (PADDR == OFS_ENABLE_SET) begin
				prdata_q <= interrupt_enable_set_d;
			end else if (PADDR == OFS_INT_STATUS) begin
				prdata_q <= status_gated;
			end else if (PADDR == OFS_CONTROL) begin
				prdata_q <= control_q;
			end else begin
				prdata_q <= '0;
			end
		end
	end

	// Reserved bits never store, so they read back as zero.
	assign PRDATA = (access && !PWRITE) ? prdata_q : '0;
	assign PSLVERR = access && pslverr_q;

	// Checks on the enables and the interrupt gate.
	a_set_takes_effect: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(wr_set && !wr_clr) |=> ((interrupt_enable_set_q & ($past(wmask) & ENABLE_MASK))
		== ($past(wmask) & ENABLE_MASK)))
		else $error("Enable set write did not set enables.");

	a_clear_takes_effect: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		wr_clr |=> ((interrupt_enable_set_q & $past(wmask) & ENABLE_MASK) == '0))
		else $error("Enable clear write left an enable set.");

	a_zero_keeps_enable: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(!wr_set && !wr_clr) |=> $stable(interrupt_enable_set_q))
		else $error("Enables changed without a write.");

	a_reserved_stay_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(interrupt_enable_set_q & ~ENABLE_MASK) == '0)
		else $error("A reserved enable bit is set.");

	a_irq_follows_gate: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		##1 IRQ == $past(|(status_gated & interrupt_enable_set_q)))
		else $error("Interrupt does not match gated flags.");

	a_masked_flag_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(interrupt_enable_set_q == 32'h0000_0001 && !status_sync[POS_MST_PENDING])
		|=> !IRQ)
		else $error("Interrupt raised without master pending.");

	a_dma_hides_pending: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(master_dma_select && dma_sync) |-> !status_gated[POS_MST_PENDING])
		else $error("Master pending passed while DMA serviced it.");

	a_timeout_raises_irq: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(interrupt_enable_set_q[POS_SCL_TIMEOUT] && status_sync[POS_SCL_TIMEOUT]) |=> IRQ)
		else $error("Clock-line time-out did not raise interrupt.");

	a_read_shows_enables: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(PSEL && !PENABLE && !PWRITE && PADDR == OFS_ENABLE_SET)
		|=> (prdata_q == interrupt_enable_set_q))
		else $error("Enable read returned wrong value.");

	// Each defined flag, once enabled, must raise the interrupt at the next clock.
	// Master pending passes only while DMA is not servicing the event.
	a_mst_pend_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MST_PENDING] && !master_dma_select
		&& interrupt_enable_set_q[POS_MST_PENDING]) |=> IRQ)
		else $error("Master pending flag did not raise interrupt.");

	// Arbitration loss is passed by its own enable.
	a_arb_loss_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MST_ARB_LOSS] && interrupt_enable_set_q[POS_MST_ARB_LOSS])
		|=> IRQ)
		else $error("Arbitration loss flag did not raise interrupt.");

	// Start/stop error is passed by its own enable.
	a_ss_err_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MST_SS_ERR] && interrupt_enable_set_q[POS_MST_SS_ERR])
		|=> IRQ)
		else $error("Start/stop error flag did not raise interrupt.");

	// Slave pending is passed by its own enable.
	a_slv_pend_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_SLV_PENDING] && interrupt_enable_set_q[POS_SLV_PENDING])
		|=> IRQ)
		else $error("Slave pending flag did not raise interrupt.");

	// Slave not-stretching is passed by its own enable.
	a_not_str_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_SLV_NOT_STR] && interrupt_enable_set_q[POS_SLV_NOT_STR])
		|=> IRQ)
		else $error("Slave not-stretching flag did not raise interrupt.");

	// Slave deselect is passed by its own enable.
	a_desel_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_SLV_DESEL] && interrupt_enable_set_q[POS_SLV_DESEL])
		|=> IRQ)
		else $error("Slave deselect flag did not raise interrupt.");

	// Monitor data-ready is passed by its own enable.
	a_mon_rdy_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MON_RDY] && interrupt_enable_set_q[POS_MON_RDY])
		|=> IRQ)
		else $error("Monitor data-ready flag did not raise interrupt.");

	// Monitor overrun is passed by its own enable.
	a_mon_over_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MON_OVER] && interrupt_enable_set_q[POS_MON_OVER])
		|=> IRQ)
		else $error("Monitor overrun flag did not raise interrupt.");

	// Monitor idle is passed by its own enable.
	a_mon_idle_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MON_IDLE] && interrupt_enable_set_q[POS_MON_IDLE])
		|=> IRQ)
		else $error("Monitor idle flag did not raise interrupt.");

	// Event time-out is passed by its own enable.
	a_evt_tmo_raises: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_EVT_TIMEOUT] && interrupt_enable_set_q[POS_EVT_TIMEOUT])
		|=> IRQ)
		else $error("Event time-out flag did not raise interrupt.");

	// With no raw flag meeting its enable, the interrupt must stay low.
	a_irq_quiet_masked: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		((status_sync & interrupt_enable_set_q) == '0) |=> !IRQ)
		else $error("Interrupt raised with no enabled flag.");

	// Read data is shown only during a read access, so idle cycles carry zero.
	a_prdata_idle_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		!(access && !PWRITE) |-> (PRDATA == '0))
		else $error("Read data driven outside a read access.");

	// A refused address or direction answers with an error in the access cycle.
	a_bad_access_err: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(access && !addr_ok) |-> PSLVERR)
		else $error("Refused access gave no error response.");

	// A legal access never answers with an error.
	a_good_access_ok: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(access && addr_ok) |-> !PSLVERR)
		else $error("Legal access gave an error response.");

	// A refused write must not touch the enables.
	a_refused_no_change: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(access && PWRITE && !addr_ok) |=> $stable(interrupt_enable_set_q))
		else $error("Refused write changed the enables.");

	// The DMA selection follows a control write with its lane strobed.
	a_ctl_write_lands: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(wr_ctl && PSTRB[0]) |=> (MASTER_DMA_SELECT == $past(PWDATA[POS_DMA_SELECT])))
		else $error("Control write did not update DMA select.");

	// Without DMA selection, master pending reaches the gate untouched.
	a_pending_without_dma: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(status_sync[POS_MST_PENDING] && !master_dma_select) |-> status_gated[POS_MST_PENDING])
		else $error("Master pending hidden without DMA selection.");

	// The status view captures the gated flags at the setup cycle.
	a_status_read_value: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(PSEL && !PENABLE && !PWRITE && PADDR == OFS_INT_STATUS)
		|=> (prdata_q == $past(status_gated)))
		else $error("Status read captured wrong value.");

	// A set write never clears an enable that was already on.
	a_set_never_clears: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		wr_set |=> ((interrupt_enable_set_q & $past(interrupt_enable_set_q))
		== $past(interrupt_enable_set_q)))
		else $error("Enable set write cleared an enable.");

	// A clear write leaves every enable outside its mask as it was.
	a_clear_keeps_others: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(wr_clr && !wr_set) |=> ((interrupt_enable_set_q & ~$past(wmask))
		== ($past(interrupt_enable_set_q) & ~$past(wmask))))
		else $error("Enable clear write touched other enables.");

	// The enable read shows the stored enables during the access cycle.
	a_enable_read_data: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(access && !PWRITE && PADDR == OFS_ENABLE_SET) |-> (PRDATA == interrupt_enable_set_q))
		else $error("Enable read data differs from the enables.");

	// Reads are free of side effects on the enables.
	a_read_keeps_enables: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		(access && !PWRITE) |=> $stable(interrupt_enable_set_q))
		else $error("A read changed the enables.");
endmodule
`default_nettype wire

// ---- src/i2cie_pkg.sv ----
// Package for the interrupt enable block of the two-wire bus controller.
// Assumes a 32-bit APB register bus and a single 200 MHz clock.
package i2cie_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h010;
	localparam int unsigned POS_MST_PENDING = 0;
	localparam int unsigned POS_MST_ARB_LOSS = 4;
	localparam int unsigned POS_MST_SS_ERR = 6;
	localparam int unsigned POS_SLV_PENDING = 8;
	localparam int unsigned POS_SLV_NOT_STR = 11;
	localparam int unsigned POS_SLV_DESEL = 15;
	localparam int unsigned POS_MON_RDY = 16;
	localparam int unsigned POS_MON_OVER = 17;
	localparam int unsigned POS_MON_IDLE = 19;
	localparam int unsigned POS_EVT_TIMEOUT = 24;
	localparam int unsigned POS_SCL_TIMEOUT = 25;
	localparam int unsigned POS_DMA_SELECT = 0;
	localparam logic [DATA_W-1:0] ENABLE_MASK = 32'h030b_8951;
	localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
	localparam int unsigned SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		I2CIE_IDLE = 2'b00,
		I2CIE_SETUP = 2'b01,
		I2CIE_ACCESS = 2'b10
	} i2cie_apb_state_t;
endpackage

// ---- src/i2cie_sync.sv ----
// Per-bit two-flop synchroniser for status flags from the bus engine.
// Assumes the flags are levels that stay set for at least two clocks.
`timescale 1ns/1ps
`default_nettype none
module i2cie_sync #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	import i2cie_pkg::*;
	logic [WIDTH-1:0] meta_q;

	// The first stage is read by the second stage only.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the interrupt enable block, driven over APB.
// Assumes the design package is compiled first and PREADY answers within 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
	import i2cie_pkg::*;
	logic REF_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0;
	logic [3:0] PSTRB = 4'h0;
	logic [DATA_W-1:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [DATA_W-1:0] STATUS_FLAGS = '0;
	logic DMA_EVENT = 1'b0;
	logic MASTER_DMA_SELECT;
	logic IRQ;
	int n_mismatch = 0;
	int checked = 0;
	int unsigned pos [11] = '{POS_MST_PENDING, POS_MST_ARB_LOSS, POS_MST_SS_ERR,
		POS_SLV_PENDING, POS_SLV_NOT_STR, POS_SLV_DESEL, POS_MON_RDY, POS_MON_OVER,
		POS_MON_IDLE, POS_EVT_TIMEOUT, POS_SCL_TIMEOUT};
	logic [DATA_W-1:0] rd;
	logic [DATA_W-1:0] exp_en;
	logic err;
	logic [3:0] strb = 4'hf;

	i2cie_top uut (.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .STATUS_FLAGS(STATUS_FLAGS),
		.DMA_EVENT(DMA_EVENT), .MASTER_DMA_SELECT(MASTER_DMA_SELECT), .IRQ(IRQ));

	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 REF_CLK = ~REF_CLK;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One APB transfer; the response is taken at the rising edge where PREADY is sampled high.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		int n;
		n = 0;
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		PSTRB <= strb;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		forever begin
			@(posedge REF_CLK);
			n++;
			if (PREADY === 1'b1) begin
				rd = PRDATA;
				err = PSLVERR;
				break;
			end
			if (n > 20) begin
				n_mismatch++;
				$display("mismatch pready exp 1 got %b", PREADY);
				final_report();
			end
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// Lets a flag pass the two synchroniser flops and the output register, then some margin.
	task automatic settle();
		repeat (5) @(posedge REF_CLK);
		@(negedge REF_CLK);
	endtask

	initial begin
		repeat (10) @(posedge REF_CLK);
		RST_B <= 1'b1;
		apb(1'b0, OFS_ENABLE_SET, '0);
		`CHK("reset enables", ENABLE_RESET, rd)
		// Set one enable at a time; earlier ones must stay set, and the read shows them all.
		exp_en = '0;
		foreach (pos[i]) begin
			exp_en[pos[i]] = 1'b1;
			apb(1'b1, OFS_ENABLE_SET, 32'h1 << pos[i]);
			apb(1'b1, OFS_ENABLE_SET, 32'h0);
			apb(1'b0, OFS_ENABLE_SET, '0);
			`CHK("enable readback", exp_en, rd)
		end
		$display("test set_readback done");
		// A flag with no enable position never raises the interrupt.
		STATUS_FLAGS <= 32'h0000_0002;
		settle();
		`CHK("irq reserved flag", 1'b0, IRQ)
		// Each flag is passed when enabled and blocked once its enable is cleared.
		foreach (pos[i]) begin
			STATUS_FLAGS <= 32'h1 << pos[i];
			settle();
			`CHK("irq enabled", 1'b1, IRQ)
			apb(1'b1, OFS_ENABLE_CLEAR, 32'h1 << pos[i]);
			settle();
			`CHK("irq masked", 1'b0, IRQ)
			apb(1'b0, OFS_ENABLE_SET, '0);
			exp_en[pos[i]] = 1'b0;
			`CHK("enable after clear", exp_en, rd)
			apb(1'b1, OFS_ENABLE_SET, 32'h1 << pos[i]);
			exp_en[pos[i]] = 1'b1;
		end
		$display("test gating done");
		// Master pending is hidden while DMA select is on and the event is DMA-serviced.
		STATUS_FLAGS <= 32'h1 << POS_MST_PENDING;
		DMA_EVENT <= 1'b1;
		apb(1'b1, OFS_CONTROL, 32'h1);
		settle();
		`CHK("dma select out", 1'b1, MASTER_DMA_SELECT)
		`CHK("irq dma event", 1'b0, IRQ)
		@(posedge REF_CLK);
		DMA_EVENT <= 1'b0;
		settle();
		`CHK("irq no dma event", 1'b1, IRQ)
		$display("test dma done");
		// The status view masks undefined flags; wrong directions are refused.
		STATUS_FLAGS <= 32'h0000_0003;
		settle();
		apb(1'b0, OFS_INT_STATUS, '0);
		`CHK("status read", 32'h0000_0001, rd)
		`CHK("status read err", 1'b0, err)
		apb(1'b0, OFS_CONTROL, '0);
		`CHK("control read", 32'h0000_0001, rd)
		apb(1'b1, OFS_INT_STATUS, 32'h0000_0000);
		`CHK("status write err", 1'b1, err)
		apb(1'b0, OFS_ENABLE_CLEAR, '0);
		`CHK("clear read err", 1'b1, err)
		`CHK("clear read data", 32'h0000_0000, rd)
		// A set write whose strobes miss a lane leaves that lane's enables alone.
		apb(1'b1, OFS_ENABLE_CLEAR, 32'h0300_0000);
		strb = 4'h1;
		apb(1'b1, OFS_ENABLE_SET, 32'h0300_0000);
		strb = 4'hf;
		apb(1'b0, OFS_ENABLE_SET, '0);
		`CHK("strobe lane kept", ENABLE_MASK & 32'hfcff_ffff, rd)
		apb(1'b1, OFS_ENABLE_SET, 32'h0300_0000);
		// An unmapped offset is refused and leaves the enables alone.
		apb(1'b1, 12'h100, 32'h0000_0000);
		`CHK("unmapped write err", 1'b1, err)
		apb(1'b0, OFS_ENABLE_SET, '0);
		`CHK("enables kept", ENABLE_MASK, rd)
		$display("test refusal done");
		// A reset in mid-run clears every enable and the DMA selection.
		RST_B <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RST_B <= 1'b1;
		apb(1'b0, OFS_ENABLE_SET, '0);
		`CHK("enables after reset", ENABLE_RESET, rd)
		apb(1'b0, OFS_CONTROL, '0);
		`CHK("control after reset", CONTROL_RESET, rd)
		settle();
		`CHK("irq after reset", 1'b0, IRQ)
		$display("test reset done");
		final_report();
	end
endmodule
`undef CHK
`default_nettype wire
